// ---- core/dmb_addr_gen.sv ----
`timescale 1ns/1ps
`include "dmb_cfg.svh"
module dmb_addr_gen (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // execute-stage request
  input wire dmb_pkg::dmb_req_t req_i,
  input wire logic ext_set_en_i,
  // peripheral register answer
  input wire logic [`DMB_DATA_W-1:0] sfr_rdata_i,
  input wire logic sfr_hit_i,
  // address trace
  output logic [`DMB_ADDR_W-1:0] addr_o,
  output logic xmap_o,
  // answer to execute stage
  output logic [`DMB_DATA_W-1:0] rdata_o,
  output logic done_o,
  output logic unimpl_o,
  // bank pointer view
  output logic [`DMB_DATA_W-1:0] bank_pointer_o,
  // peripheral register strobes
  output dmb_pkg::dmb_sfr_t sfr_o,
  // program counter low write
  output logic pc_low_wr_o,
  output logic [`DMB_DATA_W-1:0] pc_low_o
);
  import dmb_pkg::*;

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  logic [`DMB_BANK_W-1:0] bank_pointer_r;
  logic [`DMB_ADDR_W-1:0] addr_nxt;
  logic xmap_nxt;
  dmb_region_t region_nxt;
  logic [`DMB_RAM_IDX_W-1:0] ram_idx;
  logic [`DMB_DATA_W-1:0] ram_q;
  logic acc_nxt;
  logic wr_nxt;
  logic rd_nxt;
  logic ram_we;
  logic [`DMB_BANK_W-1:0] bank_of;

  // stage one state
  logic s1_valid_r;
  logic s1_rd_r;
  dmb_region_t s1_region_r;
  logic [`DMB_DATA_W-1:0] s1_ram_q_r;
  logic [`DMB_ADDR_W-1:0] addr_r;
  logic xmap_r;
  dmb_sfr_t sfr_r;
  logic pc_low_wr_r;
  logic [`DMB_DATA_W-1:0] pc_low_r;

  // stage two state
  logic [`DMB_DATA_W-1:0] rdata_r;
  logic done_r;
  logic unimpl_r;

  // ---------------------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------------------
  // a data access is a read or a write; loading the pointer touches no memory
  assign rd_nxt = (req_i.op == DMB_OP_READ);
  assign wr_nxt = (req_i.op == DMB_OP_WRITE);
  assign acc_nxt = rd_nxt || wr_nxt;

  // ---------------------------------------------------------------------------
  // address multiplexer, same cycle as the request
  // ---------------------------------------------------------------------------
  always_comb begin
    xmap_nxt = 1'b0;
    if (req_i.full_sel) begin
      // move with full addresses never looks at the pointer
      addr_nxt = req_i.full_addr;
    end else if (req_i.acc_sel) begin
      // pointer on top, operand is the offset into the bank
      addr_nxt = {bank_pointer_r, req_i.operand};
    end else begin
      // forced map: pointer ignored, one window over two bank halves
      if (req_i.operand < `DMB_ACC_SPLIT) begin
        addr_nxt = {`DMB_BANK_GPR, req_i.operand};
      end else begin
        addr_nxt = {`DMB_BANK_TOP, req_i.operand};
      end
      // extended set hands the low window to the indexed path of the core
      if (ext_set_en_i && (req_i.operand <= `DMB_XMAP_LAST)) begin
        xmap_nxt = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // region classification of the formed address
  // ---------------------------------------------------------------------------
  assign bank_of = addr_nxt[`DMB_BANK_LO -: `DMB_BANK_W];

  always_comb begin
    if (xmap_nxt) begin
      region_nxt = DMB_RG_XMAP;
    end else if (bank_of == `DMB_BANK_GPR) begin
      region_nxt = DMB_RG_GPR;
    end else if (bank_of == `DMB_BANK_TOP) begin
      if (!addr_nxt[`DMB_BANK_HI_POS]) begin
        region_nxt = DMB_RG_GPR;
      end else if (addr_nxt == `DMB_BP_ADDR) begin
        region_nxt = DMB_RG_BP;
      end else if (addr_nxt == `DMB_PCL_ADDR) begin
        region_nxt = DMB_RG_PCL;
      end else begin
        region_nxt = DMB_RG_SFR;
      end
    end else begin
      // only bank 0 and bank 15 are built
      region_nxt = DMB_RG_UNIMPL;
    end
  end

  // ---------------------------------------------------------------------------
  // general RAM: bank 0 whole, then the low half of bank 15
  // ---------------------------------------------------------------------------
  always_comb begin
    if (bank_of == `DMB_BANK_GPR) begin
      ram_idx = {1'b0, addr_nxt[`DMB_OFF_W-1:0]};
    end else begin
      ram_idx = `DMB_TOP_GPR_BASE | {2'b00, addr_nxt[`DMB_BANK_HI_POS-1:0]};
    end
  end

  // writes to unbuilt banks never reach storage
  assign ram_we = wr_nxt && (region_nxt == DMB_RG_GPR);

  dmb_gpr_ram u_ram (
    .clk_sys_i(clk_sys_i),
    .we_i(ram_we),
    .widx_i(ram_idx),
    .wdata_i(req_i.wdata),
    .ridx_i(ram_idx),
    .rdata_o(ram_q)
  );

  // ---------------------------------------------------------------------------
  // bank pointer: literal load or data write to its own address
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      bank_pointer_r <= `DMB_BP_RST;
    end else if (req_i.op == DMB_OP_LOADB) begin
      bank_pointer_r <= req_i.wdata[`DMB_BANK_W-1:0];
    end else if (wr_nxt && (region_nxt == DMB_RG_BP)) begin
      bank_pointer_r <= req_i.wdata[`DMB_BANK_W-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // stage one: address trace and access bookkeeping
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      s1_valid_r <= 1'b0;
      s1_rd_r <= 1'b0;
      s1_region_r <= DMB_RG_GPR;
      s1_ram_q_r <= 8'h00;
      addr_r <= 12'h000;
      xmap_r <= 1'b0;
    end else begin
      s1_valid_r <= acc_nxt;
      s1_rd_r <= rd_nxt;
      s1_region_r <= region_nxt;
      s1_ram_q_r <= ram_q;
      addr_r <= addr_nxt;
      xmap_r <= acc_nxt && xmap_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // stage one: strobes to the peripheral registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sfr_r <= '0;
    end else begin
      // program counter low reads come back through the peripheral path
      sfr_r.rd <= rd_nxt && ((region_nxt == DMB_RG_SFR) || (region_nxt == DMB_RG_PCL));
      sfr_r.wr <= wr_nxt && (region_nxt == DMB_RG_SFR);
      sfr_r.addr <= addr_nxt;
      sfr_r.wdata <= req_i.wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // stage one: program counter low write pulse
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pc_low_wr_r <= 1'b0;
      pc_low_r <= 8'h00;
    end else begin
      pc_low_wr_r <= wr_nxt && (region_nxt == DMB_RG_PCL);
      if (wr_nxt && (region_nxt == DMB_RG_PCL)) begin
        pc_low_r <= req_i.wdata;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // stage two: read data and completion
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rdata_r <= 8'h00;
    end else if (s1_valid_r && s1_rd_r) begin
      case (s1_region_r)
        DMB_RG_GPR: begin
          rdata_r <= s1_ram_q_r;
        end
        DMB_RG_BP: begin
          rdata_r <= {4'h0, bank_pointer_r};
        end
        DMB_RG_SFR, DMB_RG_PCL: begin
          // empty slots in the register area read zero
          rdata_r <= sfr_hit_i ? sfr_rdata_i : 8'h00;
        end
        default: begin
          rdata_r <= 8'h00;
        end
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // completion is signalled for unbuilt banks too, so flags still update
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      done_r <= 1'b0;
      unimpl_r <= 1'b0;
    end else begin
      done_r <= s1_valid_r;
      unimpl_r <= s1_valid_r && (s1_region_r == DMB_RG_UNIMPL);
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign addr_o = addr_r;
  assign xmap_o = xmap_r;
  assign rdata_o = rdata_r;
  assign done_o = done_r;
  assign unimpl_o = unimpl_r;
  assign bank_pointer_o = {4'h0, bank_pointer_r};
  assign sfr_o = sfr_r;
  assign pc_low_wr_o = pc_low_wr_r;
  assign pc_low_o = pc_low_r;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  a_bank_load_lit: assert property (
    (req_i.op == DMB_OP_LOADB) |=> (bank_pointer_o == {4'h0, $past(req_i.wdata[3:0])})
  ) else $error("bank pointer literal load not taken");

  a_bank_upper_zero: assert property (
    bank_pointer_o[7:4] == 4'h0
  ) else $error("bank pointer upper bits not zero");

  a_banked_addr_form: assert property (
    (acc_nxt && req_i.acc_sel && !req_i.full_sel)
      |=> (addr_o == {$past(bank_pointer_r), $past(req_i.operand)})
  ) else $error("banked address not pointer plus operand");

  a_access_low_half: assert property (
    (acc_nxt && !req_i.acc_sel && !req_i.full_sel && !req_i.operand[7])
      |=> (addr_o[11:8] == 4'h0) && (addr_o[7:0] == $past(req_i.operand))
  ) else $error("access map low half not in bank 0");

  a_access_high_half: assert property (
    (acc_nxt && !req_i.acc_sel && !req_i.full_sel && req_i.operand[7])
      |=> (addr_o == {4'hf, $past(req_i.operand)})
  ) else $error("access map high half not in bank 15");

  a_full_addr_move: assert property (
    (acc_nxt && req_i.full_sel) |=> (addr_o == $past(req_i.full_addr))
  ) else $error("full address move altered by bank pointer");

  a_unimpl_read_zero: assert property (
    (rd_nxt && (region_nxt == DMB_RG_UNIMPL)) |-> ##2 (done_o && unimpl_o && (rdata_o == 8'h00))
  ) else $error("unbuilt bank read not zero or not completed");

  a_pcl_write_pulse: assert property (
    (wr_nxt && (addr_nxt == 12'hff9)) |=> (pc_low_wr_o && (pc_low_o == $past(req_i.wdata)))
  ) else $error("program counter low write missed");

  a_done_latency: assert property (
    (acc_nxt && !$past(acc_nxt)) |-> ##1 !done_o ##1 done_o
  ) else $error("access not completed after two edges");

  a_xmap_extended: assert property (
    (acc_nxt && ext_set_en_i && !req_i.acc_sel && !req_i.full_sel && (req_i.operand <= 8'h5f))
      |=> xmap_o && !sfr_o.rd && !sfr_o.wr
  ) else $error("extended access map not applied");

  a_unbuilt_write_drop: assert property (
    (wr_nxt && (addr_nxt[11:8] != 4'h0) && (addr_nxt[11:8] != 4'hf))
      |-> !ram_we ##1 (!sfr_o.wr && !pc_low_wr_o)
  ) else $error("write to unbuilt bank not discarded");

  a_unbuilt_flag_set: assert property (
    (acc_nxt && (addr_nxt[11:8] != 4'h0) && (addr_nxt[11:8] != 4'hf))
      |-> ##2 (done_o && unimpl_o)
  ) else $error("unbuilt bank access not flagged");

  a_built_not_flagged: assert property (
    (acc_nxt && ((addr_nxt[11:8] == 4'h0) || (addr_nxt[11:8] == 4'hf)))
      |-> ##2 (done_o && !unimpl_o)
  ) else $error("built bank access flagged as unbuilt");

  a_bp_write_take: assert property (
    (wr_nxt && (addr_nxt == 12'hfe0))
      |=> (bank_pointer_o == {4'h0, $past(req_i.wdata[3:0])})
  ) else $error("bank pointer data write not taken");

  a_sfr_read_strobe: assert property (
    (rd_nxt && (addr_nxt[11:7] == 5'h1f) && (addr_nxt != 12'hfe0))
      |=> (sfr_o.rd && (sfr_o.addr == $past(addr_nxt)))
  ) else $error("register area read not strobed");

  a_empty_slot_zero: assert property (
    (sfr_o.rd && !sfr_hit_i) |=> (rdata_o == 8'h00)
  ) else $error("empty register slot did not read zero");

  a_pcl_no_sfr: assert property (
    (wr_nxt && (addr_nxt == 12'hff9)) |=> !sfr_o.wr
  ) else $error("program counter low write leaked to registers");

endmodule // dmb_addr_gen

// ---- common/dmb_cfg.svh ----
// Function
// - data space is 12-bit, sixteen banks of 256 bytes, top nibble picks bank
// - banked address is bank pointer on top, instruction operand as low byte
// - bank pointer keeps four bits; upper four read zero and ignore writes
// - a dedicated instruction loads a literal straight into the bank pointer
// - writes to unbuilt banks vanish; reads from them return zero
// - arithmetic flags update as if an unbuilt-bank access had succeeded
// - full-address move carries both 12-bit addresses and ignores bank pointer
// - access select one uses bank pointer with the 8-bit operand
// - access select zero uses the access map, bank pointer ignored
// - access map low half hits bank 0 bottom, high half bank 15 top
// - access-map operation completes in two cycles without touching the pointer
// - extended-set configuration bit switches to the modified access map
// - general RAM starts at 000h, never cleared by any reset
// - control registers fill F80h through FFFh at the top of bank 15
// - unused control-register slots are unbuilt and read as zero
// - banked write to F9h with pointer 0Fh lands in program counter low
// - only two of the sixteen banks are physically built
`ifndef DMB_CFG_SVH
`define DMB_CFG_SVH

// ----------------------------------------------------------------------------
// address geometry
// ----------------------------------------------------------------------------
`define DMB_ADDR_W 12
`define DMB_BANK_W 4
`define DMB_OFF_W 8
`define DMB_DATA_W 8
`define DMB_BANK_LO 11
`define DMB_BANK_HI_POS 7

// ----------------------------------------------------------------------------
// implemented banks and map boundaries
// ----------------------------------------------------------------------------
`define DMB_BANK_GPR 4'h0
`define DMB_BANK_TOP 4'hf
`define DMB_ACC_SPLIT 8'h80
`define DMB_XMAP_LAST 8'h5f
`define DMB_BP_ADDR 12'hfe0
`define DMB_PCL_ADDR 12'hff9
`define DMB_BP_RST 4'h0
`define DMB_TOP_GPR_BASE 9'h100

// ----------------------------------------------------------------------------
// general RAM storage
// ----------------------------------------------------------------------------
`define DMB_RAM_DEPTH 384
`define DMB_RAM_IDX_W 9

// ----------------------------------------------------------------------------
// pipeline timing in clock cycles
// ----------------------------------------------------------------------------
`define DMB_ANSWER_CYC 2

`endif

// ---- common/dmb_pkg.sv ----
package dmb_pkg;
`include "dmb_cfg.svh"

  // operation requested by the execute stage
  typedef enum logic [1:0] {
    DMB_OP_IDLE  = 2'h0,
    DMB_OP_READ  = 2'h1,
    DMB_OP_WRITE = 2'h3,
    DMB_OP_LOADB = 2'h2
  } dmb_op_t;

  // where a formed address lands
  typedef enum logic [2:0] {
    DMB_RG_GPR    = 3'h0,
    DMB_RG_BP     = 3'h1,
    DMB_RG_PCL    = 3'h3,
    DMB_RG_SFR    = 3'h2,
    DMB_RG_UNIMPL = 3'h6,
    DMB_RG_XMAP   = 3'h7
  } dmb_region_t;

  // one request from the execute stage
  typedef struct packed {
    dmb_op_t op;
    logic acc_sel;
    logic full_sel;
    logic [`DMB_ADDR_W-1:0] full_addr;
    logic [`DMB_OFF_W-1:0] operand;
    logic [`DMB_DATA_W-1:0] wdata;
  } dmb_req_t;

  // strobe group towards the peripheral register file
  typedef struct packed {
    logic rd;
    logic wr;
    logic [`DMB_ADDR_W-1:0] addr;
    logic [`DMB_DATA_W-1:0] wdata;
  } dmb_sfr_t;

endpackage

// ---- core/dmb_gpr_ram.sv ----
`timescale 1ns/1ps
`include "dmb_cfg.svh"
module dmb_gpr_ram (
  // clock
  input wire logic clk_sys_i,
  // write port
  input wire logic we_i,
  input wire logic [`DMB_RAM_IDX_W-1:0] widx_i,
  input wire logic [`DMB_DATA_W-1:0] wdata_i,
  // read port
  input wire logic [`DMB_RAM_IDX_W-1:0] ridx_i,
  output logic [`DMB_DATA_W-1:0] rdata_o
);
  import dmb_pkg::*;

  localparam int unsigned IDX_W = `DMB_RAM_IDX_W;

  logic [`DMB_DATA_W-1:0] mem_r [`DMB_RAM_DEPTH];

  // ---------------------------------------------------------------------------
  // storage, one byte per entry, no reset so contents survive every reset
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `DMB_RAM_DEPTH; gi++) begin : g_ent
      always_ff @(posedge clk_sys_i) begin
        if (we_i && (widx_i == IDX_W'(gi))) begin
          mem_r[gi] <= wdata_i;
        end
      end
    end
  endgenerate

  // asynchronous read, the caller registers it
  assign rdata_o = mem_r[ridx_i];

endmodule // dmb_gpr_ram

// ---- test/dmb_sfr_model.sv ----
`timescale 1ns/1ps
module dmb_sfr_model (
  // clock
  input wire logic clk_sys_i,
  // strobes from the address generator
  input wire dmb_pkg::dmb_sfr_t sfr_i,
  // combinational answer
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o
);
  import dmb_pkg::*;
  // ---------------------------------------------------------------
  // register file state
  // ---------------------------------------------------------------
  logic [7:0] regs_r [0:127];
  logic [7:0] noise_r = 8'h00;
  logic hit;
  // a small hole of unbuilt register slots
  assign hit = !(sfr_i.addr >= 12'hf85 && sfr_i.addr <= 12'hf88);
  // store writes, keep the idle pattern moving
  always @(posedge clk_sys_i) begin
    noise_r <= noise_r + 8'h5b;
    if (sfr_i.wr && hit) begin
      regs_r[sfr_i.addr[6:0]] <= sfr_i.wdata;
    end
  end
  // answer only while read is strobed, otherwise a changing pattern
  assign sfr_rdata_o = sfr_i.rd ? regs_r[sfr_i.addr[6:0]] : noise_r;
  assign sfr_hit_o = sfr_i.rd ? hit : noise_r[0];
endmodule // dmb_sfr_model

// ---- test/data_memory_bank_addressing_bench.sv ----
`timescale 1ns/1ps
module data_memory_bank_addressing_bench;
  import dmb_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk_sys_i;
  logic resetn_i;
  dmb_req_t req_i;
  logic ext_set_en_i;
  logic [7:0] sfr_rdata_i;
  logic sfr_hit_i;
  logic [11:0] addr_o;
  logic xmap_o;
  logic [7:0] rdata_o;
  logic done_o;
  logic unimpl_o;
  logic [7:0] bank_pointer_o;
  dmb_sfr_t sfr_o;
  logic pc_low_wr_o;
  logic [7:0] pc_low_o;
  int error_cnt = 0;
  int compares = 0;
  int pcl_cnt = 0;
  int xm_cnt = 0;
  int n0;

  dmb_addr_gen dmb_addr_gen_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_i(req_i),
    .ext_set_en_i(ext_set_en_i), .sfr_rdata_i(sfr_rdata_i), .sfr_hit_i(sfr_hit_i),
    .addr_o(addr_o), .xmap_o(xmap_o), .rdata_o(rdata_o), .done_o(done_o), .unimpl_o(unimpl_o),
    .bank_pointer_o(bank_pointer_o), .sfr_o(sfr_o), .pc_low_wr_o(pc_low_wr_o),
    .pc_low_o(pc_low_o));
  dmb_sfr_model dmb_sfr_model_inst (.clk_sys_i(clk_sys_i), .sfr_i(sfr_o),
    .sfr_rdata_o(sfr_rdata_i), .sfr_hit_o(sfr_hit_i));

  // ---------------------------------------------------------------
  // clock and pulse monitors
  // ---------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // count single-cycle pulses that a task could miss
  always @(posedge clk_sys_i) begin
    if (pc_low_wr_o === 1'b1) pcl_cnt++;
    if (xmap_o === 1'b1) xm_cnt++;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask
  task automatic do_reset();
    resetn_i = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    #1 resetn_i = 1'b1;
  endtask
  // one read or write, waits a bounded time for completion
  task automatic acc(input dmb_op_t op, input logic a, input logic f, input logic [11:0] fa,
                     input logic [7:0] opnd, input logic [7:0] wd);
    int n;
    req_i = {op, a, f, fa, opnd, wd};
    @(posedge clk_sys_i);
    #1 req_i.op = DMB_OP_IDLE;
    n = 0;
    while (done_o !== 1'b1 && n < 4) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    chk("done", 12'h001, {11'h0, done_o});
  endtask
  task automatic rd(input logic a, input logic f, input logic [11:0] fa, input logic [7:0] opnd,
                    input logic [11:0] ea, input logic [7:0] ed, input logic eu);
    acc(DMB_OP_READ, a, f, fa, opnd, 8'h00);
    chk("addr", ea, addr_o);
    chk("rdata", {4'h0, ed}, {4'h0, rdata_o});
    chk("unimpl", {11'h0, eu}, {11'h0, unimpl_o});
  endtask
  task automatic wr(input logic a, input logic f, input logic [11:0] fa, input logic [7:0] opnd,
                    input logic [7:0] wd, input logic [11:0] ea, input logic eu);
    acc(DMB_OP_WRITE, a, f, fa, opnd, wd);
    chk("addr", ea, addr_o);
    chk("unimpl", {11'h0, eu}, {11'h0, unimpl_o});
  endtask
  // load literal; always followed directly by a banked access
  task automatic ldb(input logic [7:0] v, input logic [11:0] eb);
    req_i = {DMB_OP_LOADB, 1'b0, 1'b0, 12'h000, 8'h00, v};
    @(posedge clk_sys_i);
    #1 chk("bank_pointer", eb, {4'h0, bank_pointer_o});
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    resetn_i = 1'b0;
    req_i = '0;
    ext_set_en_i = 1'b0;
    do_reset();
    chk("bank_pointer", 12'h000, {4'h0, bank_pointer_o});
    chk("done", 12'h000, {11'h0, done_o});
    ldb(8'hf3, 12'h003);
    wr(1, 0, 12'h000, 8'h12, 8'h5a, 12'h312, 1);
    ldb(8'h00, 12'h000);
    wr(1, 0, 12'h000, 8'h12, 8'ha5, 12'h012, 0);
    rd(1, 0, 12'h000, 8'h12, 12'h012, 8'ha5, 0);
    for (int b = 1; b < 15; b++) begin
      ldb(b[7:0], b[11:0]);
      rd(1, 0, 12'h000, 8'h12, {b[3:0], 8'h12}, 8'h00, 1);
    end
    rd(0, 0, 12'h000, 8'h12, 12'h012, 8'ha5, 0);
    wr(0, 0, 12'h000, 8'h90, 8'h3c, 12'hf90, 0);
    rd(0, 0, 12'h000, 8'h90, 12'hf90, 8'h3c, 0);
    rd(0, 0, 12'h000, 8'h85, 12'hf85, 8'h00, 0);
    rd(1, 1, 12'h012, 8'h00, 12'h012, 8'ha5, 0);
    wr(1, 1, 12'h0ff, 8'h00, 8'h11, 12'h0ff, 0);
    rd(0, 1, 12'h0ff, 8'hee, 12'h0ff, 8'h11, 0);
    ldb(8'h0f, 12'h00f);
    wr(1, 0, 12'h000, 8'h40, 8'h66, 12'hf40, 0);
    rd(1, 0, 12'h000, 8'h40, 12'hf40, 8'h66, 0);
    n0 = pcl_cnt;
    wr(1, 0, 12'h000, 8'hf9, 8'h77, 12'hff9, 0);
    chk("pcl_writes", 12'h001, 12'(pcl_cnt - n0));
    chk("pc_low", 12'h077, {4'h0, pc_low_o});
    wr(0, 0, 12'h000, 8'he0, 8'h96, 12'hfe0, 0);
    chk("bank_pointer", 12'h006, {4'h0, bank_pointer_o});
    rd(0, 0, 12'h000, 8'he0, 12'hfe0, 8'h06, 0);
    ext_set_en_i = 1'b1;
    n0 = xm_cnt;
    acc(DMB_OP_READ, 0, 0, 12'h000, 8'h12, 8'h00);
    chk("xmap", 12'h001, 12'(xm_cnt - n0));
    chk("rdata", 12'h000, {4'h0, rdata_o});
    rd(0, 0, 12'h000, 8'h90, 12'hf90, 8'h3c, 0);
    ext_set_en_i = 1'b0;
    do_reset();
    chk("bank_pointer", 12'h000, {4'h0, bank_pointer_o});
    rd(1, 0, 12'h000, 8'h12, 12'h012, 8'ha5, 0);
    test_done();
  end

  // watchdog far beyond the fewer than two hundred cycles the sequence needs
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
endmodule // data_memory_bank_addressing_bench
